// ===== logic/gpt_timer_set.sv
// Purpose: three general purpose timers (a, b, c) behind an apb slave
// Assumes: pins are synchronous to pclk; idle_mode comes from power control
// Notes: timer b/c join into one 32-bit timer when b's pair bit is set
//   timer a sync mode adds about three cycles of latency to each count
//   gate pins are registered once, so their edges are seen a cycle late; clock pin edges count in the cycle they arrive
//   a flag that hardware sets in the cycle software clears it stays set
// Behaviour
// - timer a run bit starts, stops it
// - idle stop bit halts timer in idle
// - gate enable ignored on external clock
// - prescale 1:1, 1:8, 1:64, 1:256
// - timer a sync bit synchronises external clock
// - timer a source: pin edges or pclk
// - count writes ignored in sync counter
// - b and c form 32-bit or two 16-bit
// - b, c separately lack asynchronous counter
// - b low word, c high word
// - c control ignored in pair mode
// - pair interrupt raised on c flag
// - pair interrupt on 32-bit period match
// - pair bit joins b and c
// - b run bit controls whole pair
// - b, c source: own pin or pclk
// - pair may keep running in idle
// - b, c counts feed capture/compare
// - event trigger only from the pair
// - timer modes pclk, counter modes pin
// - timer a sync after the prescaler
`include "gpt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_set
  import gpt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic timer_a_ext_clock_pin,
  input wire logic timer_b_ext_clock_pin,
  input wire logic timer_c_ext_clock_pin,
  input wire logic [2:0] gate_pin,
  output logic [2:0] timer_irq,
  output logic pair_event_trigger,
  output gpt_tbase_t time_base
);

  gpt_state_t s_ff;
  gpt_state_t nxt_s;

  // prescale terminal count for a select code
  // the prescaler counts source ticks from zero up to this value and wraps,
  // so a code gives one timer tick per top plus one source ticks; comparing
  // with >= lets a smaller code take effect even mid-count
  function automatic logic [7:0] ps_top(input logic [1:0] sel);
    case (sel)
      2'h3: ps_top = `GPT_PS_MAX;
      2'h2: ps_top = `GPT_PS_64;
      2'h1: ps_top = `GPT_PS_8;
      default: ps_top = 8'h00;
    endcase
  endfunction

  // register word of a control struct
  // unimplemented bit positions stay zero, so they read back as zero
  function automatic logic [15:0] ctrl_word(input gpt_ctrl_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`GPT_BIT_RUN] = c.run;
    w[`GPT_BIT_IDLE] = c.idle_stop;
    w[`GPT_BIT_GATE] = c.gate_accumulate_enable;
    w[`GPT_BIT_PS_HI:`GPT_BIT_PS_LO] = c.prescale_select;
    w[`GPT_BIT_PAIR] = c.pair_wide_mode;
    w[`GPT_BIT_SYNC] = c.ext_clock_sync_select;
    w[`GPT_BIT_CS] = c.clock_source_select;
    ctrl_word = w;
  endfunction

  // control struct from a written word, unimplemented bits dropped
  // the mask keeps bits that a register lacks (pair on a and c, sync on b and c) at zero
  function automatic gpt_ctrl_t ctrl_from(input logic [15:0] w, input logic [15:0] m);
    logic [15:0] v;
    gpt_ctrl_t c;
    v = w & m;
    c.run = v[`GPT_BIT_RUN];
    c.idle_stop = v[`GPT_BIT_IDLE];
    c.gate_accumulate_enable = v[`GPT_BIT_GATE];
    c.prescale_select = v[`GPT_BIT_PS_HI:`GPT_BIT_PS_LO];
    c.pair_wide_mode = v[`GPT_BIT_PAIR];
    c.ext_clock_sync_select = v[`GPT_BIT_SYNC];
    c.clock_source_select = v[`GPT_BIT_CS];
    ctrl_from = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // effective configuration per timer
  logic pair;
  gpt_ctrl_t eff [3];
  // per-timer tick terms
  logic [2:0] pin_now;
  logic [2:0] pin_rise;
  logic [2:0] src_tick;
  logic [2:0] run_ok;
  logic [2:0] psc_wrap;
  logic [2:0] inc;
  logic [2:0] match16;

  // timer a external clock path
  logic a_ext_sync;
  logic a_sync_rise;
  logic sync_count_a;

  // bus strobes
  logic wr_en;
  logic rd_en;

  // 32-bit view of the b/c pair
  logic [31:0] pair_cnt;
  logic [31:0] pair_per;
  logic pair_match;

  // pair bit joins b and c
  assign pair = s_ff.ctrl[1].pair_wide_mode;
  // in pair mode timer c runs entirely from b's control word
  // c uses b control in pair mode
  assign eff[0] = s_ff.ctrl[0];
  assign eff[1] = s_ff.ctrl[1];
  assign eff[2] = pair ? s_ff.ctrl[1] : s_ff.ctrl[2];
  // c clock and gate taken from b in pair mode
  assign pin_now = {pair ? timer_b_ext_clock_pin : timer_c_ext_clock_pin,
                    timer_b_ext_clock_pin, timer_a_ext_clock_pin};
  assign a_ext_sync = eff[0].clock_source_select & eff[0].ext_clock_sync_select;
  // synchronous counter mode locks count writes
  assign sync_count_a = a_ext_sync & eff[0].run;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  // b low word, c high word
  assign pair_cnt = {s_ff.cnt[2], s_ff.cnt[1]};
  assign pair_per = {s_ff.per[2], s_ff.per[1]};
  assign pair_match = pair_cnt == pair_per;

  // the third stage only remembers the last synchronised level
  // edge of the synchronised prescaler output for timer a
  assign a_sync_rise = s_ff.a_sync2 & ~s_ff.a_sync3;

  ////////////////////////////////////////////////////////////////////////////
  // per-timer tick logic
  // clock pins are compared live against last cycle's sample, so a rising edge is
  // counted in the cycle it reaches the pin; a pin pulse must stay high
  // for at least one clock to be seen
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      logic gate_sel;
      // rising edge against last cycle's pin sample
      assign pin_rise[gi] = pin_now[gi] & ~s_ff.pin_q[gi];
      // b, c own pin or pclk
      // timer modes on pclk, counters on pin
      assign src_tick[gi] = eff[gi].clock_source_select ? pin_rise[gi] : 1'b1;
      assign gate_sel = eff[gi].gate_accumulate_enable & ~eff[gi].clock_source_select;
      // run bit, b run drives pair
      // idle stop halts, runs in idle when clear
      // gated mode counts only while gate high
      assign run_ok[gi] = eff[gi].run & ~(eff[gi].idle_stop & idle_mode) &
                          (~gate_sel | s_ff.gate_q[gi]);
      assign psc_wrap[gi] = s_ff.psc[gi] >= ps_top(eff[gi].prescale_select);
      // 16-bit compare against the period register
      assign match16[gi] = s_ff.cnt[gi] == s_ff.per[gi];
    end
  endgenerate

  // b and c tick from their own run bits only while separate; in pair mode
  // c advances solely on the carry out of b, and never on the matching tick,
  // because that tick clears both halves
  // timer a synchronised counter ticks on synced prescaler output
  // only timer a has the asynchronous path; b, c always pclk based
  assign inc[0] = run_ok[0] & (a_ext_sync ? a_sync_rise : (src_tick[0] & psc_wrap[0]));
  assign inc[1] = run_ok[1] & src_tick[1] & psc_wrap[1];
  assign inc[2] = pair ? inc[1] & (s_ff.cnt[1] == 16'hffff) & ~pair_match
                       : run_ok[2] & src_tick[2] & psc_wrap[2];

  // flags are sticky until software clears them
  // pair interrupt leaves b flag quiet
  assign timer_irq = s_ff.flag;
  // event trigger only in pair mode
  assign pair_event_trigger = pair & s_ff.flag[2];
  assign time_base = '{timer_b: s_ff.cnt[1], timer_c: s_ff.cnt[2], pair: pair};
  // every register answers in its first access cycle, so there are no wait
  // states and no error responses; unmapped offsets simply read as zero
  assign prdata = s_ff.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // next state; later sections override earlier ones, so a bus write to a
  // count or period wins over a timer tick in the same cycle
  always_comb begin
    logic [2:0] flag_set;
    flag_set = 3'h0;
    nxt_s = s_ff;
    // pin and gate samples for edge detection and gating
    nxt_s.pin_q = pin_now;
    nxt_s.gate_q = {pair ? gate_pin[1] : gate_pin[2], gate_pin[1:0]};
    // prescaler output toggles into a two-stage synchroniser
    nxt_s.a_sync1 = s_ff.psc[0] == 8'h00 && s_ff.pin_q[0];
    nxt_s.a_sync2 = s_ff.a_sync1;
    nxt_s.a_sync3 = s_ff.a_sync2;

    // prescalers advance on every source tick while running
    // a stopped timer restarts its prescaler from zero
    for (int i = 0; i < 3; i++) begin
      if (run_ok[i] && src_tick[i]) begin
        nxt_s.psc[i] = psc_wrap[i] ? 8'h00 : 8'(s_ff.psc[i] + 8'h01);
      end
      if (!eff[i].run) begin
        nxt_s.psc[i] = 8'h00;
      end
    end

    // 16-bit counting for a, and for b, c when separate
    for (int i = 0; i < 3; i++) begin
      if (inc[i] && !(pair && i != 0)) begin
        // match zeroes count and sets flag
        if (match16[i]) begin
          nxt_s.cnt[i] = 16'h0000;
          nxt_s.flag[i] = 1'b1;
          flag_set[i] = 1'b1;
        end else begin
          nxt_s.cnt[i] = 16'(s_ff.cnt[i] + 16'h0001);
        end
      end
    end

    // 32-bit pair counting
    // the pair compares on each b tick, so it wraps exactly at the pair period
    if (pair && inc[1]) begin
      if (pair_match) begin
        nxt_s.cnt[1] = 16'h0000;
        nxt_s.cnt[2] = 16'h0000;
        nxt_s.flag[2] = 1'b1;
        flag_set[2] = 1'b1;
      end else begin
        nxt_s.cnt[1] = 16'(s_ff.cnt[1] + 16'h0001);
        // c follows the carry out of b
        if (inc[2]) begin
          nxt_s.cnt[2] = 16'(s_ff.cnt[2] + 16'h0001);
        end
      end
    end

    // register writes; flag clears lose to a same-cycle set, also when the
    // flag was already set and sets again while software clears it
    if (wr_en) begin
      // control words keep only implemented bits
      if (paddr == `GPT_OFF_A_CTRL) begin
        nxt_s.ctrl[0] = ctrl_from(pwdata[15:0], `GPT_A_CTRL_MASK);
      end else if (paddr == `GPT_OFF_B_CTRL) begin
        nxt_s.ctrl[1] = ctrl_from(pwdata[15:0], `GPT_B_CTRL_MASK);
      end else if (paddr == `GPT_OFF_C_CTRL) begin
        nxt_s.ctrl[2] = ctrl_from(pwdata[15:0], `GPT_C_CTRL_MASK);
      end else if (paddr == `GPT_OFF_A_CNT) begin
        // write ignored in sync counter mode
        if (!sync_count_a) begin
          nxt_s.cnt[0] = pwdata[15:0];
        end
      end else if (paddr == `GPT_OFF_B_CNT) begin
        nxt_s.cnt[1] = pwdata[15:0];
      end else if (paddr == `GPT_OFF_C_CNT) begin
        nxt_s.cnt[2] = pwdata[15:0];
      end else if (paddr == `GPT_OFF_A_PER) begin
        // a new period is used from the next compare
        nxt_s.per[0] = pwdata[15:0];
      end else if (paddr == `GPT_OFF_B_PER) begin
        nxt_s.per[1] = pwdata[15:0];
      end else if (paddr == `GPT_OFF_C_PER) begin
        nxt_s.per[2] = pwdata[15:0];
      end else if (paddr == `GPT_OFF_FLAGS) begin
        // write one to clear, hardware set wins
        nxt_s.flag = (s_ff.flag & ~pwdata[2:0]) | flag_set;
      end
    end

    // read data captured in setup phase, stable through access
    // capturing early keeps prdata on a flip-flop and steady in the access
    // phase even though the counts move every cycle
    if (rd_en) begin
      if (paddr == `GPT_OFF_A_CTRL) begin
        nxt_s.prdata = {16'h0000, ctrl_word(s_ff.ctrl[0])};
      end else if (paddr == `GPT_OFF_B_CTRL) begin
        nxt_s.prdata = {16'h0000, ctrl_word(s_ff.ctrl[1])};
      end else if (paddr == `GPT_OFF_C_CTRL) begin
        nxt_s.prdata = {16'h0000, ctrl_word(s_ff.ctrl[2])};
      end else if (paddr == `GPT_OFF_A_CNT) begin
        nxt_s.prdata = {16'h0000, s_ff.cnt[0]};
      end else if (paddr == `GPT_OFF_B_CNT) begin
        nxt_s.prdata = {16'h0000, s_ff.cnt[1]};
      end else if (paddr == `GPT_OFF_C_CNT) begin
        nxt_s.prdata = {16'h0000, s_ff.cnt[2]};
      end else if (paddr == `GPT_OFF_A_PER) begin
        nxt_s.prdata = {16'h0000, s_ff.per[0]};
      end else if (paddr == `GPT_OFF_B_PER) begin
        nxt_s.prdata = {16'h0000, s_ff.per[1]};
      end else if (paddr == `GPT_OFF_C_PER) begin
        nxt_s.prdata = {16'h0000, s_ff.per[2]};
      end else if (paddr == `GPT_OFF_FLAGS) begin
        nxt_s.prdata = {29'h0, s_ff.flag};
      end else begin
        // unmapped offsets read as zero
        nxt_s.prdata = 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; periods reset to all ones so a fresh timer runs the
  // full 16-bit range before its first match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.per <= {3{`GPT_PER_RST}};
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule
`default_nettype wire

// ===== logic/gpt_defines.svh
// Purpose: offsets, field positions and reset values of the timer set
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: control fields are shared by all three control registers
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH
`define GPT_OFF_A_CTRL 12'h000
`define GPT_OFF_B_CTRL 12'h004
`define GPT_OFF_C_CTRL 12'h008
`define GPT_OFF_A_CNT 12'h010
`define GPT_OFF_B_CNT 12'h014
`define GPT_OFF_C_CNT 12'h018
`define GPT_OFF_A_PER 12'h020
`define GPT_OFF_B_PER 12'h024
`define GPT_OFF_C_PER 12'h028
`define GPT_OFF_FLAGS 12'h030
`define GPT_BIT_RUN 15
`define GPT_BIT_IDLE 13
`define GPT_BIT_GATE 6
`define GPT_BIT_PS_HI 5
`define GPT_BIT_PS_LO 4
`define GPT_BIT_PAIR 3
`define GPT_BIT_SYNC 2
`define GPT_BIT_CS 1
`define GPT_A_CTRL_MASK 16'ha076
`define GPT_B_CTRL_MASK 16'ha07a
`define GPT_C_CTRL_MASK 16'ha072
`define GPT_CTRL_RST 16'h0000
`define GPT_PER_RST 16'hffff
`define GPT_PS_MAX 8'hff
`define GPT_PS_64 8'h3f
`define GPT_PS_8 8'h07
`endif

// ===== logic/gpt_pkg.sv
// Purpose: types of the timer set
// Assumes: gpt_defines.svh holds all numbers
// Notes: one packed struct carries all module state
package gpt_pkg;
  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic pair_wide_mode;
    logic ext_clock_sync_select;
    logic clock_source_select;
  } gpt_ctrl_t;
  typedef struct packed {
    gpt_ctrl_t [2:0] ctrl;
    logic [2:0][15:0] cnt;
    logic [2:0][15:0] per;
    logic [2:0][7:0] psc;
    logic [2:0] pin_q;
    logic [2:0] gate_q;
    logic [2:0] flag;
    logic a_sync1;
    logic a_sync2;
    logic a_sync3;
    logic [31:0] prdata;
  } gpt_state_t;
  typedef struct packed {
    logic [15:0] timer_b;
    logic [15:0] timer_c;
    logic pair;
  } gpt_tbase_t;
endpackage

// ===== verif/gpt_asserts.sv
// Purpose: port checks of the timer set
// Assumes: apb write lands at psel and penable
// Notes: b control mirrored from bus writes
`timescale 1ns/1ps
`default_nettype none
module gpt_asserts
  import gpt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic idle_mode,
  input wire logic [2:0] timer_irq,
  input wire logic pair_event_trigger,
  input wire gpt_tbase_t time_base
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic [15:0] b_ctrl_ff;
  assign wr = psel && penable && pwrite;
  // copy of b control; needed since control is not a port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_ctrl_ff <= 16'h0000;
    end else if (wr && paddr == 12'h004) begin
      b_ctrl_ff <= pwdata[15:0];
    end
  end
  // two quiet cycles tolerate one stage of tick pipeline
  sequence s_b_off;
    (!wr && (!b_ctrl_ff[15] || (idle_mode && b_ctrl_ff[13])))[*2];
  endsequence
  AST_B_HOLD: assert property (s_b_off |=> $stable(time_base.timer_b))
    else $error("b count moved while stopped");
  AST_TRIG: assert property (pair_event_trigger == (time_base.pair && timer_irq[2]))
    else $error("event trigger not from pair flag");
  AST_NO_B_FLAG: assert property (time_base.pair |=> !$rose(timer_irq[1]))
    else $error("b flag set in pair mode");
  AST_PAIR_BIT: assert property (time_base.pair == b_ctrl_ff[3])
    else $error("pair mode differs from b control");
  AST_B_WRAP: assert property ($rose(timer_irq[1]) |-> time_base.timer_b == 16'h0000)
    else $error("b count not zero at match");
  AST_C_WRAP: assert property ($rose(timer_irq[2]) && time_base.pair |->
    {time_base.timer_c, time_base.timer_b} == 32'h0)
    else $error("pair count not zero at match");
  AST_CARRY: assert property ($past(time_base.pair) && !$past(wr) && $changed(time_base.timer_c) |->
    time_base.timer_b == 16'h0000)
    else $error("c moved without carry from b");
  AST_B_STEP: assert property (!$past(wr) && $changed(time_base.timer_b) |->
    time_base.timer_b == $past(time_base.timer_b) + 16'h0001 || time_base.timer_b == 16'h0000)
    else $error("b count jumped");
endmodule
`default_nettype wire

// ===== verif/gpt_pins.sv
// Purpose: pin side of the timer set
// Assumes: pins change just after pclk rises
// Notes: a disabled clock pin rests low
`timescale 1ns/1ps
`default_nettype none
module gpt_pins (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] clk_on,
  input wire logic [2:0] gate_on,
  output logic [2:0] ext_clk,
  output logic [2:0] gate
);
  logic [1:0] ph_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_ff <= 2'h0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
    end
  end
  // clock pins stand still when off
  assign ext_clk = clk_on & {3{ph_ff[1]}};
  assign gate = gate_on;
endmodule
`default_nettype wire

// ===== verif/gpt_timer_set_bench.sv
// Purpose: self-checking bench of the timer set
// Assumes: zero-wait apb, pins paced by gpt_pins
// Notes: rates are count deltas between two reads
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_set_bench import gpt_pkg::*;;
  typedef struct {bit w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} gpt_row_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, idle_mode = 1'h0;
  logic pready, pslverr, trig, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [2:0] clk_on = 3'h0, gate_on = 3'h0, ext_clk, gate, irq;
  gpt_tbase_t tbase;
  int error_cnt = 0, check_count = 0, cyc = 0;
  int div [4] = '{1, 8, 64, 256};
  gpt_row_t rows [8];
  gpt_timer_set u_gpt_timer_set (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .idle_mode, .timer_a_ext_clock_pin(ext_clk[0]), .timer_b_ext_clock_pin(ext_clk[1]),
    .timer_c_ext_clock_pin(ext_clk[2]), .gate_pin(gate), .timer_irq(irq), .pair_event_trigger(trig),
    .time_base(tbase));
  gpt_pins u_gpt_pins (.pclk, .presetn, .clk_on, .gate_on, .ext_clk, .gate);
  initial begin
    forever #4 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 1700 cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; read data taken at the pready edge
  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // two count reads exactly m cycles apart, so prescaler phase drops out
  task automatic rate(input logic [11:0] ca, input logic [15:0] cv, input int m, input logic [15:0] e);
    logic [15:0] c0;
    xfer(1'h1, ca, {16'h0000, cv});
    xfer(1'h0, ca + 12'h010, 32'h0);
    c0 = rv[15:0];
    repeat (m - 3) @(posedge pclk);
    xfer(1'h0, ca + 12'h010, 32'h0);
    chk("count delta", {16'h0000, e}, {16'h0000, rv[15:0] - c0});
  endtask
  initial begin
    rows = '{'{1'h0, 12'h004, 32'h0, 32'h0}, '{1'h0, 12'h024, 32'h0, 32'hffff}, '{1'h0, 12'h030, 32'h0, 32'h0},
      '{1'h1, 12'h000, 32'h7fff, 32'h2076}, '{1'h1, 12'h004, 32'h7fff, 32'h207a},
      '{1'h1, 12'h008, 32'h7fff, 32'h2072}, '{1'h1, 12'h03c, 32'hffff, 32'h0}, '{1'h1, 12'h014, 32'habcd, 32'habcd}};
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) xfer(1'h1, rows[i].a, rows[i].d);
      xfer(1'h0, rows[i].a, 32'h0);
      chk("register", rows[i].e, rv);
      chk("slverr", 32'h0, {31'h0, se});
    end
    chk("time base b", 32'habcd, {16'h0000, tbase.timer_b});
    chk("time base pair", 32'h1, {31'h0, tbase.pair});
    for (int p = 0; p < 4; p++) begin
      rate(12'h000, 16'h8000 | 16'(p << 4), 3 * div[p], 16'h3);
    end
    rate(12'h000, 16'h0000, 40, 16'h0);
    idle_mode <= 1'h1;
    rate(12'h000, 16'ha000, 40, 16'h0);
    rate(12'h000, 16'h8000, 40, 16'h28);
    idle_mode <= 1'h0;
    rate(12'h000, 16'h8040, 40, 16'h0);
    gate_on <= 3'h7;
    rate(12'h000, 16'h8040, 40, 16'h28);
    clk_on <= 3'h7;
    gate_on <= 3'h0;
    rate(12'h000, 16'h8042, 64, 16'h10);
    rate(12'h000, 16'h8006, 64, 16'h10);
    xfer(1'h1, 12'h010, 32'h5555);
    xfer(1'h0, 12'h010, 32'h0);
    chk("sync write", 32'h0, {31'h0, rv[15:0] == 16'h5555});
    rate(12'h004, 16'h8002, 64, 16'h10);
    rate(12'h008, 16'h8012, 64, 16'h2);
    xfer(1'h1, 12'h004, 32'h0);
    xfer(1'h1, 12'h014, 32'h0);
    xfer(1'h1, 12'h024, 32'h5);
    xfer(1'h1, 12'h004, 32'h8000);
    repeat (8) @(posedge pclk);
    xfer(1'h1, 12'h004, 32'h0);
    xfer(1'h0, 12'h030, 32'h0);
    chk("b flag", 32'h2, rv);
    chk("irq pins", 32'h2, {29'h0, irq});
    xfer(1'h1, 12'h030, 32'h2);
    xfer(1'h0, 12'h030, 32'h0);
    chk("flag clear", 32'h0, rv);
    // c control left stopped: the pair must count anyway
    xfer(1'h1, 12'h004, 32'h8);
    xfer(1'h1, 12'h008, 32'h0);
    xfer(1'h1, 12'h014, 32'hfff0);
    xfer(1'h1, 12'h018, 32'h0);
    xfer(1'h1, 12'h024, 32'h8);
    xfer(1'h1, 12'h028, 32'h1);
    idle_mode <= 1'h1;
    xfer(1'h1, 12'h004, 32'h8008);
    repeat (30) @(posedge pclk);
    chk("pair trigger", 32'h1, {31'h0, trig});
    xfer(1'h1, 12'h004, 32'h8);
    xfer(1'h0, 12'h030, 32'h0);
    chk("pair flag", 32'h4, rv);
    chk("pair irq pins", 32'h4, {29'h0, irq});
    chk("pair bit", 32'h1, {31'h0, tbase.pair});
    idle_mode <= 1'h0;
    // mid-run reset: registers and pins return to their reset values
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, 12'h004, 32'h0);
    chk("reset b ctrl", 32'h0, rv);
    xfer(1'h0, 12'h028, 32'h0);
    chk("reset c period", 32'hffff, rv);
    chk("reset irq pins", 32'h0, {29'h0, irq});
    chk("reset pair bit", 32'h0, {31'h0, tbase.pair});
    stop_test();
  end
endmodule
bind gpt_timer_set gpt_asserts u_gpt_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .idle_mode, .timer_irq, .pair_event_trigger, .time_base);
`default_nettype wire
